// *** include/dac_trim_pkg.sv ***
// constants shared by the dither and offset trim register bank
package dac_trim_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] LEFT_DITHER_A_IDX  = 8'h49; // left dither, high byte
    localparam logic [7:0] LEFT_DITHER_B_IDX  = 8'h4a; // left dither, low byte
    localparam logic [7:0] RIGHT_DITHER_A_IDX = 8'h4b; // right dither, high byte
    localparam logic [7:0] RIGHT_DITHER_B_IDX = 8'h4c; // right dither, low byte
    localparam logic [7:0] LEFT_TRIM_IDX      = 8'h4e; // left output offset trim
    localparam logic [7:0] RIGHT_TRIM_IDX     = 8'h4f; // right output offset trim

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int         REG_W          = 8;     // every register is one byte
    localparam int         DITHER_W       = 11;    // q0.11 dither, unit 1/32 fs
    localparam int         DITHER_HI_W    = 3;     // bits taken from the high byte
    localparam int         TRIM_W         = 9;     // negated trim needs one more bit
    localparam int         WORD_SHIFT     = 2;     // byte address to word index
    localparam logic [7:0] REG_RESET      = 8'h00; // all registers clear to zero
    localparam logic [1:0] WORD_ALIGN     = 2'h0;  // low address bits of an aligned word
    localparam int         MIN_ADDR_W     = 9;     // highest index times four fits here
    localparam int         MIN_MOD_W      = 12;    // modulator word must exceed dither

    // ------------------------------------------------------------
    // register selector
    // ------------------------------------------------------------
    typedef enum {
        SEL_NONE,
        SEL_LEFT_DITHER_A,
        SEL_LEFT_DITHER_B,
        SEL_RIGHT_DITHER_A,
        SEL_RIGHT_DITHER_B,
        SEL_LEFT_TRIM,
        SEL_RIGHT_TRIM
    } reg_sel_t;

endpackage : dac_trim_pkg

// *** hw/dac_dither_offset_regs.sv ***
// apb register bank for secondary dc dither and output offset trim
//
// What this block does
// - left dither byte pair adds to left modulator
// - right dither byte pair adds to right modulator
// - dither is unsigned q0.11, one equals 1/32 fs
// - zero code adds nothing; lsb weighs 2^-11
// - left output offset is negated code over four
// - right offset uses same negated quarter scaling
// - trim code is signed; extremes map negated
//
// only byte lane 0 carries a register.
// a low enable stalls the bus, never drops it.
// trim leaves as a number; volts are analog's job.
// every byte clears to zero on reset.
`timescale 1ns/1ps
`default_nettype none

module dac_dither_offset_regs #(
    parameter int ADDR_W = 12, // apb byte address width
    parameter int MOD_W  = 24  // secondary modulator input width
) (
    // ------------------------------------------------------------
    // clock, reset, enable
    // ------------------------------------------------------------
    input  wire logic                    pclk,            // 100 mhz system clock
    input  wire logic                    presetn,         // async reset, active low
    input  wire logic                    clk_en,          // low freezes all state
    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    input  wire logic                    psel,            // slave select
    input  wire logic                    penable,         // access phase
    input  wire logic                    pwrite,          // write when high
    input  wire logic [ADDR_W-1:0]       paddr,           // byte address
    input  wire logic [31:0]             pwdata,          // write data
    input  wire logic [3:0]              pstrb,           // byte lane strobes
    output logic                         pready,          // transfer completes
    output logic [31:0]                  prdata,          // read data, registered
    output logic                         pslverr,         // unmapped address
    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    input  wire logic signed [MOD_W-1:0] left_mod_in,     // left modulator word
    input  wire logic signed [MOD_W-1:0] right_mod_in,    // right modulator word
    output logic signed [MOD_W-1:0]      left_mod_out,    // left word plus dither
    output logic signed [MOD_W-1:0]      right_mod_out,   // right word plus dither
    output logic [10:0]                  left_dither,     // left q0.11 dither
    output logic [10:0]                  right_dither,    // right q0.11 dither
    output logic signed [8:0]            left_offset_qmv, // left offset, quarter mv
    output logic signed [8:0]            right_offset_qmv // right offset, quarter mv
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // both checks stop elaboration early
    // a wider bus just leaves space unmapped
    // the highest register index times four must be addressable
    if (ADDR_W < dac_trim_pkg::MIN_ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W too small for the register map");
    end
    // dither must sit strictly below the sign bit of the modulator word
    if (MOD_W < dac_trim_pkg::MIN_MOD_W) begin : g_bad_mod_w
        $error("MOD_W too small to carry the dither");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // compare a byte address with a register index
    // low address bits must be zero to match
    function automatic logic addr_hits(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        logic [ADDR_W-1:0] want; // byte address of the index
        want = ADDR_W'({idx, dac_trim_pkg::WORD_ALIGN});
        return addr == want;
    endfunction : addr_hits

    // join the byte pair, high byte at the lower address
    // high byte bits 7:3 are kept but unused
    function automatic logic [10:0] join_dither(input logic [7:0] hi, input logic [7:0] lo);
        return {hi[dac_trim_pkg::DITHER_HI_W-1:0], lo};
    endfunction : join_dither

    // add the unsigned dither into the low bits, clamp at positive full scale
    function automatic logic signed [MOD_W-1:0] add_dither(
        input logic signed [MOD_W-1:0] word,
        input logic [10:0]             dith
    );
        logic signed [MOD_W:0] wide; // one guard bit against overflow
        // unsigned dither: zero-extended, never sign-extended
        wide = {word[MOD_W-1], word} + (MOD_W+1)'(dith);
        // a positive addend can only overflow upward; clamp rather than wrap,
        // since a wrap would throw the modulator from full positive to full negative
        if (wide[MOD_W] != wide[MOD_W-1]) begin
            return {1'b0, {(MOD_W-1){1'b1}}};
        end else begin
            return wide[MOD_W-1:0];
        end
    endfunction : add_dither

    // negate the signed trim code; needs nine bits so that 0x80 becomes +128
    // eight bits would wrap that code onto itself
    function automatic logic signed [8:0] negate_trim(input logic [7:0] code);
        logic signed [8:0] ext; // sign-extended code
        ext = {code[7], code};
        return -ext;
    endfunction : negate_trim

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    dac_trim_pkg::reg_sel_t sel;        // register addressed by paddr
    logic                   setup_ph;   // first cycle of a transfer
    logic                   access_ph;  // second and later cycles
    logic                   wr_take;    // a write takes effect now
    logic                   answer_ok;  // read word and error captured

    // decode is shared by read capture, write enable and error
    // misaligned addresses fall into the error path
    always_comb begin
        sel = dac_trim_pkg::SEL_NONE;
        if (addr_hits(paddr, dac_trim_pkg::LEFT_DITHER_A_IDX)) begin
            sel = dac_trim_pkg::SEL_LEFT_DITHER_A;
        end else if (addr_hits(paddr, dac_trim_pkg::LEFT_DITHER_B_IDX)) begin
            sel = dac_trim_pkg::SEL_LEFT_DITHER_B;
        end else if (addr_hits(paddr, dac_trim_pkg::RIGHT_DITHER_A_IDX)) begin
            sel = dac_trim_pkg::SEL_RIGHT_DITHER_A;
        end else if (addr_hits(paddr, dac_trim_pkg::RIGHT_DITHER_B_IDX)) begin
            sel = dac_trim_pkg::SEL_RIGHT_DITHER_B;
        end else if (addr_hits(paddr, dac_trim_pkg::LEFT_TRIM_IDX)) begin
            sel = dac_trim_pkg::SEL_LEFT_TRIM;
        end else if (addr_hits(paddr, dac_trim_pkg::RIGHT_TRIM_IDX)) begin
            sel = dac_trim_pkg::SEL_RIGHT_TRIM;
        end
    end

    // phases of the apb transfer
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    // ready waits for the captured answer: a frozen block holds the access
    // phase open instead of losing the write or showing a stale read word
    assign pready    = clk_en & answer_ok;
    // writes land only on the completing edge of a mapped, lane-0 access
    assign wr_take   = access_ph & pready & pwrite & pstrb[0] & (sel != dac_trim_pkg::SEL_NONE);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] left_dither_a;       // left dither high byte
    logic [7:0] left_dither_b;       // left dither low byte
    logic [7:0] right_dither_a;      // right dither high byte
    logic [7:0] right_dither_b;      // right dither low byte
    logic [7:0] left_trim;           // left output offset trim
    logic [7:0] right_trim;          // right output offset trim
    logic [7:0] next_left_dither_a;  // next left high byte
    logic [7:0] next_left_dither_b;  // next left low byte
    logic [7:0] next_right_dither_a; // next right high byte
    logic [7:0] next_right_dither_b; // next right low byte
    logic [7:0] next_left_trim;      // next left trim
    logic [7:0] next_right_trim;     // next right trim

    // software writes; all six are plain read/write bytes
    // lanes 1 to 3 of the write word are ignored
    always_comb begin
        next_left_dither_a  = left_dither_a;
        next_left_dither_b  = left_dither_b;
        next_right_dither_a = right_dither_a;
        next_right_dither_b = right_dither_b;
        next_left_trim      = left_trim;
        next_right_trim     = right_trim;
        if (wr_take) begin
            unique case (sel)
                dac_trim_pkg::SEL_LEFT_DITHER_A:  next_left_dither_a  = pwdata[7:0];
                dac_trim_pkg::SEL_LEFT_DITHER_B:  next_left_dither_b  = pwdata[7:0];
                dac_trim_pkg::SEL_RIGHT_DITHER_A: next_right_dither_a = pwdata[7:0];
                dac_trim_pkg::SEL_RIGHT_DITHER_B: next_right_dither_b = pwdata[7:0];
                dac_trim_pkg::SEL_LEFT_TRIM:      next_left_trim      = pwdata[7:0];
                dac_trim_pkg::SEL_RIGHT_TRIM:     next_right_trim     = pwdata[7:0];
                dac_trim_pkg::SEL_NONE:           next_left_trim      = left_trim;
            endcase
        end
    end

    // register the bytes; reset clears everything
    // a low enable freezes every byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_dither_a  <= dac_trim_pkg::REG_RESET;
            left_dither_b  <= dac_trim_pkg::REG_RESET;
            right_dither_a <= dac_trim_pkg::REG_RESET;
            right_dither_b <= dac_trim_pkg::REG_RESET;
            left_trim      <= dac_trim_pkg::REG_RESET;
            right_trim     <= dac_trim_pkg::REG_RESET;
        end else if (clk_en) begin
            left_dither_a  <= next_left_dither_a;
            left_dither_b  <= next_left_dither_b;
            right_dither_a <= next_right_dither_a;
            right_dither_b <= next_right_dither_b;
            left_trim      <= next_left_trim;
            right_trim     <= next_right_trim;
        end
    end

    // ------------------------------------------------------------
    // read data and error capture
    // ------------------------------------------------------------
    logic [31:0] next_prdata;  // read word for this address
    logic        next_pslverr; // error for this address
    logic        next_answer_ok; // next capture state

    // captured in the setup cycle, or in the first enabled access cycle when
    // the enable was low at the setup edge; the write of this transfer cannot
    // land before its completing edge, so the captured word is never stale
    always_comb begin
        next_prdata    = prdata;
        next_pslverr   = pslverr;
        next_answer_ok = answer_ok;
        if (!psel) begin
            // idle: error only stands during its own transfer
            next_pslverr   = 1'b0;
            next_answer_ok = 1'b0;
        end else if (setup_ph || !answer_ok) begin
            // fresh transfer, or a capture missed while frozen
            next_prdata    = '0;
            next_pslverr   = 1'b0;
            next_answer_ok = 1'b1;
            unique case (sel)
                dac_trim_pkg::SEL_LEFT_DITHER_A:  next_prdata[7:0] = left_dither_a;
                dac_trim_pkg::SEL_LEFT_DITHER_B:  next_prdata[7:0] = left_dither_b;
                dac_trim_pkg::SEL_RIGHT_DITHER_A: next_prdata[7:0] = right_dither_a;
                dac_trim_pkg::SEL_RIGHT_DITHER_B: next_prdata[7:0] = right_dither_b;
                dac_trim_pkg::SEL_LEFT_TRIM:      next_prdata[7:0] = left_trim;
                dac_trim_pkg::SEL_RIGHT_TRIM:     next_prdata[7:0] = right_trim;
                // unmapped: read zero and flag the error
                dac_trim_pkg::SEL_NONE:           next_pslverr     = 1'b1;
            endcase
        end else begin
            // completing edge: next transfer captures afresh
            next_answer_ok = 1'b0;
        end
    end

    // register the answer; no capture pending out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata    <= '0;
            pslverr   <= 1'b0;
            answer_ok <= 1'b0;
        end else if (clk_en) begin
            prdata    <= next_prdata;
            pslverr   <= next_pslverr;
            answer_ok <= next_answer_ok;
        end
    end

    // ------------------------------------------------------------
    // datapath: dither sum and offset trim
    // ------------------------------------------------------------
    logic signed [MOD_W-1:0] next_left_mod_out;      // left sum
    logic signed [MOD_W-1:0] next_right_mod_out;     // right sum
    logic [10:0]             next_left_dither;       // left joined dither
    logic [10:0]             next_right_dither;      // right joined dither
    logic signed [8:0]       next_left_offset_qmv;   // left negated trim
    logic signed [8:0]       next_right_offset_qmv;  // right negated trim

    // sums clamp, never wrap, at full scale
    // one cycle of latency; sums use the dither already in force,
    // so a new dither value reaches the sum two cycles after its write
    always_comb begin
        next_left_dither      = join_dither(left_dither_a, left_dither_b);
        next_right_dither     = join_dither(right_dither_a, right_dither_b);
        next_left_mod_out     = add_dither(left_mod_in, left_dither);
        next_right_mod_out    = add_dither(right_mod_in, right_dither);
        next_left_offset_qmv  = negate_trim(left_trim);
        next_right_offset_qmv = negate_trim(right_trim);
    end

    // register the datapath outputs
    // cleared so the modulator starts undithered
    // a low enable holds the sums as well
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_mod_out     <= '0;
            right_mod_out    <= '0;
            left_dither      <= '0;
            right_dither     <= '0;
            left_offset_qmv  <= '0;
            right_offset_qmv <= '0;
        end else if (clk_en) begin
            left_mod_out     <= next_left_mod_out;
            right_mod_out    <= next_right_mod_out;
            left_dither      <= next_left_dither;
            right_dither     <= next_right_dither;
            left_offset_qmv  <= next_left_offset_qmv;
            right_offset_qmv <= next_right_offset_qmv;
        end
    end

endmodule : dac_dither_offset_regs

`default_nettype wire

// *** test/dac_dither_offset_regs_properties.sv ***
// concurrent checks for the dither and offset trim register bank
`timescale 1ns/1ps
`default_nettype none
module dac_trim_checker #(
    parameter int ADDR_W = 12, // apb byte address width
    parameter int MOD_W  = 24  // modulator word width
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    clk_en,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [ADDR_W-1:0]       paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic                    pready,
    input wire logic [31:0]             prdata,
    input wire logic                    pslverr,
    input wire logic signed [MOD_W-1:0] left_mod_in,
    input wire logic signed [MOD_W-1:0] right_mod_in,
    input wire logic signed [MOD_W-1:0] left_mod_out,
    input wire logic signed [MOD_W-1:0] right_mod_out,
    input wire logic [10:0]             left_dither,
    input wire logic [10:0]             right_dither,
    input wire logic signed [8:0]       left_offset_qmv,
    input wire logic signed [8:0]       right_offset_qmv
);
    // ------------------------------------------------------------
    // helper decode
    // ------------------------------------------------------------
    logic [ADDR_W-3:0] idx;    // word index of the access
    logic [7:0]        wbyte;  // written byte lane
    logic [2:0]        whi;    // bits kept by a high dither byte
    logic              wr_ok;  // aligned, strobed write lands now
    logic              mapped; // access hits a register
    assign idx = paddr[ADDR_W-1:2];
    assign wbyte = pwdata[7:0];
    assign whi = pwdata[2:0];
    assign wr_ok = psel & penable & pready & pwrite & clk_en & pstrb[0]
        & (paddr[1:0] == dac_trim_pkg::WORD_ALIGN);
    assign mapped = (paddr[1:0] == dac_trim_pkg::WORD_ALIGN) && (idx inside {[dac_trim_pkg::LEFT_DITHER_A_IDX:
        dac_trim_pkg::RIGHT_DITHER_B_IDX], dac_trim_pkg::LEFT_TRIM_IDX, dac_trim_pkg::RIGHT_TRIM_IDX});
    // dither only ever raises the word, so only positive overflow clamps
    function automatic logic signed [MOD_W-1:0] sat(logic signed [MOD_W-1:0] w, logic [10:0] d);
        logic [MOD_W:0] s;
        s = {w[MOD_W-1], w} + {{(MOD_W-10){1'b0}}, d};
        return (!w[MOD_W-1] && s[MOD_W-1]) ? {1'b0, {(MOD_W-1){1'b1}}} : s[MOD_W-1:0];
    endfunction : sat
    function automatic logic signed [8:0] neg9(logic [7:0] c);
        return -$signed({c[7], c});
    endfunction : neg9
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    left_dither_lo_a: assert property (wr_ok && idx == dac_trim_pkg::LEFT_DITHER_B_IDX
        |-> ##2 left_dither[7:0] == $past(wbyte, 2)) else $error("left dither low byte lost");
    left_dither_hi_a: assert property (wr_ok && idx == dac_trim_pkg::LEFT_DITHER_A_IDX
        |-> ##2 left_dither[10:8] == $past(whi, 2)) else $error("left dither high bits lost");
    right_dither_lo_a: assert property (wr_ok && idx == dac_trim_pkg::RIGHT_DITHER_B_IDX
        |-> ##2 right_dither[7:0] == $past(wbyte, 2)) else $error("right dither low byte lost");
    right_dither_hi_a: assert property (wr_ok && idx == dac_trim_pkg::RIGHT_DITHER_A_IDX
        |-> ##2 right_dither[10:8] == $past(whi, 2)) else $error("right dither high bits lost");
    dither_hold_a: assert property ($changed(left_dither) |-> $past(wr_ok, 2))
        else $error("left dither moved without a write");
    left_dither_add_a: assert property ($past(clk_en) && $past(presetn)
        |-> left_mod_out == sat($past(left_mod_in), $past(left_dither))) else $error("left sum wrong");
    right_dither_add_a: assert property ($past(clk_en) && $past(presetn)
        |-> right_mod_out == sat($past(right_mod_in), $past(right_dither))) else $error("right sum wrong");
    left_offset_neg_a: assert property (wr_ok && idx == dac_trim_pkg::LEFT_TRIM_IDX
        |-> ##2 left_offset_qmv == neg9($past(wbyte, 2))) else $error("left offset wrong");
    right_offset_neg_a: assert property (wr_ok && idx == dac_trim_pkg::RIGHT_TRIM_IDX
        |-> ##2 right_offset_qmv == neg9($past(wbyte, 2))) else $error("right offset wrong");
    hole_error_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error flag disagrees with address map");
    cover property (wr_ok && idx == dac_trim_pkg::LEFT_TRIM_IDX);
    cover property (psel && penable && pslverr);
    cover property (psel && penable && !pready);
    cover property (right_mod_out == {1'b0, {(MOD_W-1){1'b1}}});
endmodule : dac_trim_checker

bind dac_dither_offset_regs dac_trim_checker #(.ADDR_W(ADDR_W), .MOD_W(MOD_W)) chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .left_mod_in(left_mod_in), .right_mod_in(right_mod_in), .left_mod_out(left_mod_out),
    .right_mod_out(right_mod_out), .left_dither(left_dither), .right_dither(right_dither),
    .left_offset_qmv(left_offset_qmv), .right_offset_qmv(right_offset_qmv));
`default_nettype wire

// *** test/dac_dither_offset_regs_tb.sv ***
// self-checking bench for the dither and offset trim register bank
`timescale 1ns/1ps
`default_nettype none
module dac_dither_offset_regs_tb;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic               pclk;
    logic               presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0000_0000;
    logic [3:0]         pstrb = 4'h0;
    logic signed [23:0] lin = 24'h00_0000, rin = 24'h00_0000, lout, rout;
    logic               pready, pslverr, er;
    logic [31:0]        prdata, rd;
    logic [10:0]        ldith, rdith;
    logic signed [8:0]  loff, roff;
    int                 err_count = 0, check_count = 0;
    // register table in address order and one pattern for each
    logic [7:0]         ix [6] = '{dac_trim_pkg::LEFT_DITHER_A_IDX, dac_trim_pkg::LEFT_DITHER_B_IDX,
        dac_trim_pkg::RIGHT_DITHER_A_IDX, dac_trim_pkg::RIGHT_DITHER_B_IDX, dac_trim_pkg::LEFT_TRIM_IDX,
        dac_trim_pkg::RIGHT_TRIM_IDX};
    logic [7:0]         val [6] = '{8'hfd, 8'h3c, 8'h02, 8'hff, 8'h7f, 8'h80};

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    dac_dither_offset_regs #(.ADDR_W(12), .MOD_W(24)) dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .left_mod_in(lin), .right_mod_in(rin),
        .left_mod_out(lout), .right_mod_out(rout), .left_dither(ldith), .right_dither(rdith),
        .left_offset_qmv(loff), .right_offset_qmv(roff));

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction : ad

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; waits for pready, never assumes a latency
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // no cap here: only the watchdog ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wrt(input logic [7:0] i, input logic [7:0] v);
        xfer(1'b1, ad(i), {24'h00_0000, v}, 4'hf);
    endtask : wrt

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        chk(rd, exp);
        chk({31'h0000_0000, er}, {31'h0000_0000, experr});
    endtask : rchk

    task automatic complete_run();
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rchk(ad(ix[i]), 32'h0000_0000, 1'b0);
        for (int i = 0; i < 6; i++) wrt(ix[i], val[i]);
        for (int i = 0; i < 6; i++) rchk(ad(ix[i]), {24'h00_0000, val[i]}, 1'b0);
        lin <= 24'h00_1000;
        rin <= 24'h7f_ffff;
        repeat (3) @(posedge pclk);
        #1;
        chk(ldith, {val[0][2:0], val[1]});
        chk(rdith, {val[2][2:0], val[3]});
        chk(lout, 32'h0000_1000 + {val[0][2:0], val[1]});
        chk(rout, 32'h007f_ffff);
        chk(loff, -$signed({val[4][7], val[4]}));
        chk(roff, -$signed({val[5][7], val[5]}));
        // sign of a negative word survives the add; lsb weight; code boundaries
        rin <= 24'hff_f000;
        wrt(ix[4], 8'hff);
        wrt(ix[5], 8'h00);
        wrt(ix[0], 8'h00);
        wrt(ix[1], 8'h01);
        repeat (3) @(posedge pclk);
        #1;
        chk(rout, 32'hffff_f2ff);
        chk(loff, 32'h0000_0001);
        chk(roff, 32'h0000_0000);
        chk(lout, 32'h0000_1001);
        wrt(ix[1], 8'h00);
        repeat (3) @(posedge pclk);
        #1;
        chk(lout, 32'h0000_1000);
        // enable low at the setup edge: bus stalls, state holds
        @(posedge pclk);
        clk_en <= 1'b0;
        lin <= 24'h00_2000;
        fork
            rchk(ad(ix[4]), 32'h0000_00ff, 1'b0);
            begin
                repeat (4) @(posedge pclk);
                #1;
                chk(lout, 32'h0000_1000);
                chk({31'h0000_0000, pready}, 32'h0000_0000);
                @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        #1;
        chk(lout, 32'h0000_2000);
        // refused accesses: hole, misaligned, no strobe
        rchk(ad(8'h4d), 32'h0000_0000, 1'b1);
        rchk(ad(ix[0]) | 12'h001, 32'h0000_0000, 1'b1);
        xfer(1'b1, ad(ix[4]), 32'h0000_0055, 4'h0);
        xfer(1'b1, ad(8'h4d), 32'h0000_0055, 4'hf);
        rchk(ad(ix[4]), 32'h0000_00ff, 1'b0);
        // second reset in mid-run clears every register
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rchk(ad(ix[4]), 32'h0000_0000, 1'b0);
        chk(loff, 32'h0000_0000);
        complete_run();
    end

    // watchdog: the sequence needs about 115 cycles
    initial begin
        repeat (3000) @(posedge pclk);
        err_count++;
        complete_run();
    end
endmodule : dac_dither_offset_regs_tb
`default_nettype wire
